// >>> hw/mic_pkg.sv
package mic_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_PIN_TIMER_FLAG = 8'h00;
  localparam logic [7:0] OFS_ONCHIP_FLAG    = 8'h04;
  localparam logic [7:0] OFS_WAKEUP_FLAG    = 8'h08;
  localparam logic [7:0] OFS_EDGE_SELECT    = 8'h0c;
  localparam logic [7:0] OFS_ENABLE_ONE     = 8'h10;
  localparam logic [7:0] OFS_ENABLE_TWO     = 8'h14;
  localparam logic [7:0] OFS_PIN_FUNCTION   = 8'h18;
  localparam logic [7:0] OFS_WAKEUP_FUNC    = 8'h1c;
  localparam logic [7:0] OFS_TIMER_CTRL     = 8'h20;
  localparam logic [7:0] OFS_STATUS         = 8'h24;

  // field positions
  localparam int ENA1_WAKEUP_BIT  = 5;
  localparam int TFH_BIT          = 3;
  localparam int TFL_BIT          = 2;
  localparam int ONCHIP_RSVD1_BIT = 1;
  localparam int ONCHIP_RSVD0_BIT = 0;
  localparam int PIN_FLAG_RSVD    = 5;

  // reset values and fixed bits
  localparam logic [7:0] ONCHIP_FLAG_RESET = 8'h01;
  localparam logic [7:0] ONCHIP_FLAG_MASK  = 8'hdc;
  localparam logic [7:0] PIN_FLAG_RESET    = 8'h20;
  localparam logic [7:0] PIN_FLAG_MASK     = 8'hdf;
  localparam logic [7:0] BYTE_ZERO         = 8'h00;

  // vector numbers
  localparam logic [4:0] VEC_PIN_BASE = 5'h04;
  localparam logic [4:0] VEC_WAKEUP   = 5'h09;
  localparam logic [4:0] VEC_INT_BASE = 5'h0a;
  localparam logic [4:0] VEC_INT_LAST = 5'h14;

  // exception sequence lengths in states
  localparam logic [3:0] SAVE_STATES  = 4'h4;
  localparam logic [3:0] FETCH_STATES = 4'h2;
  localparam logic [3:0] IFETCH_STATES = 4'h4;
  localparam logic [3:0] INTERNAL_STATES = 4'h4;

  typedef enum logic [2:0] {
    MIC_IDLE,
    MIC_WAIT_INSN,
    MIC_SAVE,
    MIC_VECTOR,
    MIC_IFETCH,
    MIC_INTERNAL
  } mic_state_t;

  typedef struct packed {
    logic [7:0] timer_f_low_counter;
    logic [7:0] timer_f_high_counter;
    logic [7:0] timer_f_low_compare;
    logic [7:0] timer_f_high_compare;
  } mic_timer_f_t;

  typedef struct packed {
    logic       save_req;
    logic       set_mask;
    logic       vector_fetch;
    logic [4:0] vector_number;
    logic       handler_start;
  } mic_cpu_ctl_t;

endpackage : mic_pkg

// >>> hw/mic_interrupt_controller.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
// Summary of operation
// RL1: timer high flag sets on high match, or 16-bit match in combined mode.
// RL2: timer low flag sets on low 8-bit match in split mode.
// RL3: flags clear only by writing 0; writing 1 never sets them.
// RL4: second flag register bit 1 reads 0, bit 0 reads 1, unwritable.
// RL5: eight wakeup flags set on falling edge of wakeup-configured pins.
// RL6: acceptance leaves the request flag set.
// RL7: wakeup requests need wakeup enable; global mask blocks everything.
// RL8: all wakeup sources share vector 9.
// RL9: each pin interrupt edge polarity chosen by its edge select bit.
// RL10: pin flag sets on selected edge when configured; disabled pin blocked.
// RL11: pin interrupts use vectors 4 to 8, pin 0 highest.
// RL12: eleven internal sources, own enables, vectors 10 to 20; code wires seven, vectors 10 to 19.
// RL13: highest fixed priority pending source wins, others stay pending.
// RL14: accept only while mask bit is 0, else keep pending.
// RL15: finish current instruction, then save program counter and flags.
// RL16: after saving state, set the global mask bit.
// RL17: emit vector number, fetch handler address, start handler.
// RL18: software should clear enables or flags only while masked.
// RL19: a clear racing an arriving request still yields exception processing.
// RL20: sequence is save 4, vector 2, fetch 4, internal 4 states.
// RL21: flags saved as a word; restore takes even byte only.
// RL22: pins synchronised by two flops, edges from sampled history.
module mic_interrupt_controller
  import mic_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  // apb slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // pins
  input  wire logic [4:0]           pin_irq_in,
  input  wire logic [7:0]           wakeup_pin_in,
  // peripheral event pulses and timer f state
  input  wire logic [15:0]          periph_event_in,
  input  wire mic_pkg::mic_timer_f_t timer_f_in,
  // cpu side
  input  wire logic                 insn_done_in,
  output mic_pkg::mic_cpu_ctl_t     cpu_ctl_out,
  output logic                      mask_bit_out,
  output logic      [15:0]          saved_flags_out
);
  import mic_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  pin_and_timer_flag_reg_q;
  logic [7:0]  onchip_timer_flag_reg_q;
  logic [7:0]  wakeup_flag_reg_q;
  logic [7:0]  edge_select_reg_q;
  logic [7:0]  enable_reg_one_q;
  logic [7:0]  enable_reg_two_q;
  logic [4:0]  pin_function_q;
  logic [7:0]  wakeup_function_q;
  logic        timer_16bit_mode_q;
  logic        mask_q;
  logic [7:0]  cond_flags_q;
  logic [7:0]  cond_flags_restore;
  logic [4:0]  pin_s1_q;
  logic [4:0]  pin_s2_q;
  logic [4:0]  pin_s3_q;
  logic [7:0]  wk_s1_q;
  logic [7:0]  wk_s2_q;
  logic [7:0]  wk_s3_q;
  mic_state_t  state_q;
  logic [3:0]  cnt_q;
  logic [4:0]  vec_q;

  wire wr = psel_in && penable_in && pwrite_in;
  wire [7:0] wb = pwdata_in[7:0];
  assign cond_flags_restore = BYTE_ZERO;

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
      wk_s1_q  <= '1;
      wk_s2_q  <= '1;
      wk_s3_q  <= '1;
    end
    else
    begin
      pin_s1_q <= pin_irq_in;    // RL22
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      wk_s1_q  <= wakeup_pin_in;
      wk_s2_q  <= wk_s1_q;
      wk_s3_q  <= wk_s2_q;
    end
  end

  logic [4:0] pin_edge;
  logic [7:0] wk_fall;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_pin
      // edge select 1 picks rising, 0 falling
      assign pin_edge[gi] = pin_function_q[gi] &&
        (edge_select_reg_q[gi] ? (pin_s2_q[gi] && !pin_s3_q[gi])
                               : (!pin_s2_q[gi] && pin_s3_q[gi])); // RL9 RL10
    end
    for (gi = 0; gi < 8; gi++)
    begin : g_wk
      assign wk_fall[gi] = wakeup_function_q[gi] && !wk_s2_q[gi] && wk_s3_q[gi]; // RL5
    end
  endgenerate

  // ****************************************
  // timer f compare events
  // ****************************************
  wire tfh_match = timer_16bit_mode_q
    ? ({timer_f_in.timer_f_high_counter, timer_f_in.timer_f_low_counter} ==
       {timer_f_in.timer_f_high_compare, timer_f_in.timer_f_low_compare})
    : (timer_f_in.timer_f_high_counter == timer_f_in.timer_f_high_compare); // RL1
  wire tfl_match = !timer_16bit_mode_q &&
    (timer_f_in.timer_f_low_counter == timer_f_in.timer_f_low_compare);   // RL2

  // internal events 2..4 and 6..7 map into onchip register, 15..14 into pin register bits 7..6
  logic [7:0] onchip_set;
  logic [7:0] pin_set;
  always_comb
  begin
    onchip_set = periph_event_in[7:0] & ONCHIP_FLAG_MASK;
    onchip_set[TFH_BIT] = onchip_set[TFH_BIT] | tfh_match;
    onchip_set[TFL_BIT] = onchip_set[TFL_BIT] | tfl_match;
    pin_set = {periph_event_in[15:14], 1'b0, pin_edge};
  end

  // ****************************************
  // flag registers: set wins over clear
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_and_timer_flag_reg_q <= PIN_FLAG_RESET;
      onchip_timer_flag_reg_q  <= ONCHIP_FLAG_RESET;
      wakeup_flag_reg_q        <= BYTE_ZERO;
    end
    else
    begin
      // writing 1 keeps, writing 0 clears, event sets; acceptance never clears
      pin_and_timer_flag_reg_q <= (((wr && paddr_in == OFS_PIN_TIMER_FLAG) ?
        (pin_and_timer_flag_reg_q & wb) : pin_and_timer_flag_reg_q) | pin_set) & PIN_FLAG_MASK
        | PIN_FLAG_RESET;                                              // RL3 RL6 RL19
      onchip_timer_flag_reg_q  <= (((wr && paddr_in == OFS_ONCHIP_FLAG) ?
        (onchip_timer_flag_reg_q & wb) : onchip_timer_flag_reg_q) | onchip_set) & ONCHIP_FLAG_MASK
        | ONCHIP_FLAG_RESET;                                           // RL3 RL4
      wakeup_flag_reg_q        <= ((wr && paddr_in == OFS_WAKEUP_FLAG) ?
        (wakeup_flag_reg_q & wb) : wakeup_flag_reg_q) | wk_fall;       // RL3 RL5
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      edge_select_reg_q  <= BYTE_ZERO;
      enable_reg_one_q   <= BYTE_ZERO;
      enable_reg_two_q   <= BYTE_ZERO;
      pin_function_q     <= '0;
      wakeup_function_q  <= BYTE_ZERO;
      timer_16bit_mode_q <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr_in == OFS_EDGE_SELECT)
        edge_select_reg_q <= wb;
      else if (paddr_in == OFS_ENABLE_ONE)
        enable_reg_one_q <= wb;
      else if (paddr_in == OFS_ENABLE_TWO)
        enable_reg_two_q <= wb & ONCHIP_FLAG_MASK;
      else if (paddr_in == OFS_PIN_FUNCTION)
        pin_function_q <= wb[4:0];
      else if (paddr_in == OFS_WAKEUP_FUNC)
        wakeup_function_q <= wb;
      else if (paddr_in == OFS_TIMER_CTRL)
        timer_16bit_mode_q <= wb[0];
    end
  end

  // ****************************************
  // priority selection
  // ****************************************
  // source order: pins 0..4 (vec 4..8), wakeup (9), internal bits (10..)
  logic [15:0] pend;
  always_comb
  begin
    pend[4:0] = pin_and_timer_flag_reg_q[4:0] & enable_reg_one_q[4:0];       // RL10
    pend[5]   = |wakeup_flag_reg_q && enable_reg_one_q[ENA1_WAKEUP_BIT];     // RL7 RL8
    pend[6]   = pin_and_timer_flag_reg_q[7] & enable_reg_one_q[7];
    pend[7]   = pin_and_timer_flag_reg_q[6] & enable_reg_one_q[6];
    pend[15:8] = onchip_timer_flag_reg_q & enable_reg_two_q & ONCHIP_FLAG_MASK; // RL12
  end

  logic       any_pend;
  logic [4:0] sel_vec;
  always_comb
  begin
    any_pend = 1'b0;
    sel_vec  = VEC_INT_LAST;
    for (int i = 15; i >= 0; i--)
    begin
      if (pend[i])
      begin
        any_pend = 1'b1;
        sel_vec  = VEC_PIN_BASE + 5'(i);  // RL11 RL13
      end
    end
  end

  // ****************************************
  // exception sequence
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= MIC_IDLE;
      cnt_q   <= '0;
      vec_q   <= VEC_PIN_BASE;
      mask_q  <= 1'b1;
      cond_flags_q <= BYTE_ZERO;
    end
    else
    begin
      case (state_q)
        MIC_IDLE:
        begin
          if (any_pend && !mask_q)      // RL14 RL7
            state_q <= MIC_WAIT_INSN;
          else if (wr && paddr_in == OFS_STATUS)
            mask_q <= wb[0];
        end
        MIC_WAIT_INSN:
          if (insn_done_in)             // RL15
          begin
            vec_q   <= sel_vec;         // RL17
            cond_flags_q <= {7'h00, mask_q} | cond_flags_restore;
            cnt_q   <= SAVE_STATES - 4'h1;
            state_q <= MIC_SAVE;
          end
        MIC_SAVE:
          if (cnt_q == '0)
          begin
            mask_q  <= 1'b1;            // RL16
            cnt_q   <= FETCH_STATES - 4'h1;
            state_q <= MIC_VECTOR;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        MIC_VECTOR:
          if (cnt_q == '0)
          begin
            cnt_q   <= IFETCH_STATES - 4'h1;
            state_q <= MIC_IFETCH;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        MIC_IFETCH:
          if (cnt_q == '0)
          begin
            cnt_q   <= INTERNAL_STATES - 4'h1;
            state_q <= MIC_INTERNAL;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        MIC_INTERNAL:
          if (cnt_q == '0)
            state_q <= MIC_IDLE;        // RL20
          else
            cnt_q <= cnt_q - 4'h1;
        default:
          state_q <= MIC_IDLE;
      endcase
    end
  end

  always_comb
  begin
    cpu_ctl_out.save_req      = (state_q == MIC_SAVE);
    cpu_ctl_out.set_mask      = (state_q == MIC_SAVE) && (cnt_q == '0);
    cpu_ctl_out.vector_fetch  = (state_q == MIC_VECTOR);
    cpu_ctl_out.vector_number = vec_q;
    cpu_ctl_out.handler_start = (state_q == MIC_INTERNAL) && (cnt_q == '0);
  end
  assign mask_bit_out    = mask_q;
  // flags pushed as a full word; cpu restores from the even byte only
  assign saved_flags_out = {cond_flags_q, cond_flags_q};   // RL21

  // ****************************************
  // apb read
  // ****************************************
  assign pready_out = 1'b1;
  always_comb
  begin
    prdata_out  = '0;
    pslverr_out = 1'b0;
    if (paddr_in == OFS_PIN_TIMER_FLAG)
      prdata_out[7:0] = pin_and_timer_flag_reg_q;
    else if (paddr_in == OFS_ONCHIP_FLAG)
      prdata_out[7:0] = onchip_timer_flag_reg_q;
    else if (paddr_in == OFS_WAKEUP_FLAG)
      prdata_out[7:0] = wakeup_flag_reg_q;
    else if (paddr_in == OFS_EDGE_SELECT)
      prdata_out[7:0] = edge_select_reg_q;
    else if (paddr_in == OFS_ENABLE_ONE)
      prdata_out[7:0] = enable_reg_one_q;
    else if (paddr_in == OFS_ENABLE_TWO)
      prdata_out[7:0] = enable_reg_two_q | ONCHIP_FLAG_RESET;
    else if (paddr_in == OFS_PIN_FUNCTION)
      prdata_out[4:0] = pin_function_q;
    else if (paddr_in == OFS_WAKEUP_FUNC)
      prdata_out[7:0] = wakeup_function_q;
    else if (paddr_in == OFS_TIMER_CTRL)
      prdata_out[0] = timer_16bit_mode_q;
    else if (paddr_in == OFS_STATUS)
      prdata_out[8:0] = {vec_q, 3'(state_q), mask_q};
    else
      pslverr_out = psel_in && penable_in;
  end

  // ****************************************
  // checks
  // ****************************************
  // every set wakeup flag survives any cycle without a write to its register
  property p_flag_sticky;
    @(posedge mclk_in) disable iff (rst_in)
    !(wr && paddr_in == OFS_WAKEUP_FLAG) |=>
      ((wakeup_flag_reg_q & $past(wakeup_flag_reg_q)) == $past(wakeup_flag_reg_q));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without write"); // RL6

  property p_rsvd;
    @(posedge mclk_in) disable iff (rst_in)
    onchip_timer_flag_reg_q[ONCHIP_RSVD0_BIT] && !onchip_timer_flag_reg_q[ONCHIP_RSVD1_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong"); // RL4

  property p_masked_idle;
    @(posedge mclk_in) disable iff (rst_in)
    (state_q == MIC_IDLE && mask_q) |=> state_q != MIC_WAIT_INSN;
  endproperty
  a_masked_idle: assert property (p_masked_idle) else $error("accepted while masked"); // RL14

  property p_seq_len;
    @(posedge mclk_in) disable iff (rst_in)
    $rose(cpu_ctl_out.save_req) |-> ##3 cpu_ctl_out.set_mask ##1 cpu_ctl_out.vector_fetch [*2]
      ##8 cpu_ctl_out.handler_start;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("sequence length wrong"); // RL20

  property p_mask_set;
    @(posedge mclk_in) disable iff (rst_in)
    cpu_ctl_out.set_mask |=> mask_q;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set"); // RL16

  property p_vec_range;
    @(posedge mclk_in) disable iff (rst_in)
    cpu_ctl_out.vector_fetch |-> (vec_q >= VEC_PIN_BASE && vec_q <= VEC_INT_LAST);
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range"); // RL17

  property p_wk_set;
    @(posedge mclk_in) disable iff (rst_in)
    (|wk_fall) |=> ((wakeup_flag_reg_q & $past(wk_fall)) == $past(wk_fall));
  endproperty
  a_wk_set: assert property (p_wk_set) else $error("wakeup flag not set"); // RL5

  property p_tfl;
    @(posedge mclk_in) disable iff (rst_in)
    tfl_match |=> onchip_timer_flag_reg_q[TFL_BIT];
  endproperty
  a_tfl: assert property (p_tfl) else $error("timer low flag not set"); // RL2

endmodule // mic_interrupt_controller

// >>> testbench/mic_cpu_model.sv
`timescale 1ns/100ps
module mic_cpu_model
(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  // controller side
  input  wire mic_pkg::mic_cpu_ctl_t ctl_in,
  input  wire logic                 slow_in,
  output logic                      insn_done_out,
  // observation
  output logic [4:0]                vec_out,
  output logic [3:0]                save_cnt_out,
  output logic [3:0]                fetch_cnt_out,
  output logic [7:0]                starts_out
);
  import mic_pkg::*;
  // ***********************************
  // instruction stream
  // ***********************************
  logic [3:0] len_q;
  logic       busy_q;
  // instructions retire only outside the exception sequence
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in) len_q <= 4'h0;
    else if (busy_q || len_q == 4'h0) len_q <= slow_in ? 4'hc : 4'h0;
    else len_q <= len_q - 4'h1;
  assign insn_done_out = !busy_q && len_q == 4'h0;
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in) busy_q <= 1'b0;
    else if (ctl_in.handler_start) busy_q <= 1'b0;
    else if (ctl_in.save_req) busy_q <= 1'b1;
  // ***********************************
  // sequence record
  // ***********************************
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in)
    begin
      save_cnt_out  <= 4'h0;
      fetch_cnt_out <= 4'h0;
    end
    else if (ctl_in.save_req && !busy_q)
    begin
      save_cnt_out  <= 4'h1;
      fetch_cnt_out <= 4'h0;
    end
    else
    begin
      if (ctl_in.save_req) save_cnt_out <= save_cnt_out + 4'h1;
      if (ctl_in.vector_fetch) fetch_cnt_out <= fetch_cnt_out + 4'h1;
    end
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in)
    begin
      vec_out    <= 5'h00;
      starts_out <= 8'h00;
    end
    else if (ctl_in.handler_start)
    begin
      vec_out    <= ctl_in.vector_number;
      starts_out <= starts_out + 8'h01;
    end
endmodule // mic_cpu_model

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import mic_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r_v;
  logic pready, pslverr, e_v, mask_bit, slow = 1'b0, insn_done;
  logic [4:0] pin_irq = 5'h1f, vec;
  logic [7:0] wk_pin = 8'hff, starts;
  logic [15:0] ev = 16'h0, saved;
  logic [3:0] save_n, fetch_n;
  mic_timer_f_t tmr = '{8'h00, 8'h00, 8'hff, 8'hff};
  mic_cpu_ctl_t ctl;
  int n_errors = 0, checks = 0, cyc = 0, lat;
  always #2.5 mclk_in = ~mclk_in;
  mic_interrupt_controller i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pin_irq_in(pin_irq),
    .wakeup_pin_in(wk_pin), .periph_event_in(ev), .timer_f_in(tmr),
    .insn_done_in(insn_done), .cpu_ctl_out(ctl),
    .mask_bit_out(mask_bit), .saved_flags_out(saved));
  mic_cpu_model i_cpu (.mclk_in(mclk_in), .rst_in(rst_in), .ctl_in(ctl),
    .slow_in(slow), .insn_done_out(insn_done), .vec_out(vec),
    .save_cnt_out(save_n), .fetch_cnt_out(fetch_n), .starts_out(starts));
  // ***********************************
  // tasks
  // ***********************************
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do @(posedge mclk_in); while (pready !== 1'b1);
    r_v = prdata;
    e_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, e}, r_v);
  endtask
  // unmask, then count cycles until the handler starts
  task automatic go(input logic [7:0] n0);
    wr(OFS_STATUS, 8'h00);
    lat = 0;
    while (starts == n0 && lat < 60)
    begin
      @(posedge mclk_in);
      lat++;
    end
  endtask
  task automatic seq(input logic [4:0] v, input logic [7:0] n0);
    go(n0);
    chk("vector", {27'h0, v}, {27'h0, vec});
    chk("save", 32'h4, {28'h0, save_n});
    chk("fetch", 32'h2, {28'h0, fetch_n});
    // lat runs two cycles past the 15 to 27 window: mask write to wait, start seen one edge late
    chk("lat", 32'h1, {31'h0, lat >= 17 && lat <= 29});
    chk("mask", 32'h1, {31'h0, mask_bit});
    chk("cond_flags", 32'h0, {16'h0, saved});
  endtask
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  // ***********************************
  // tests
  // ***********************************
  initial
  begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(OFS_PIN_TIMER_FLAG, 8'h20, "pin_rst");
    rd(OFS_ONCHIP_FLAG, 8'h01, "chip_rst");
    rd(OFS_WAKEUP_FLAG, 8'h00, "wk_rst");
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, e_v});
    wr(OFS_ONCHIP_FLAG, 8'hff);
    rd(OFS_ONCHIP_FLAG, 8'h01, "chip_w1");
    tmr.timer_f_low_compare <= 8'h00;
    repeat (3) @(posedge mclk_in);
    rd(OFS_ONCHIP_FLAG, 8'h05, "tfl");
    tmr.timer_f_high_compare <= 8'h00;
    repeat (3) @(posedge mclk_in);
    rd(OFS_ONCHIP_FLAG, 8'h0d, "tfh");
    tmr <= '{8'h00, 8'h00, 8'hff, 8'hff};
    wr(OFS_ONCHIP_FLAG, 8'h00);
    rd(OFS_ONCHIP_FLAG, 8'h01, "chip_w0");
    wr(OFS_TIMER_CTRL, 8'h01);
    tmr.timer_f_low_compare <= 8'h00;
    repeat (3) @(posedge mclk_in);
    rd(OFS_ONCHIP_FLAG, 8'h01, "no_tfl16");
    tmr.timer_f_high_compare <= 8'h00;
    repeat (3) @(posedge mclk_in);
    rd(OFS_ONCHIP_FLAG, 8'h09, "tfh16");
    tmr <= '{8'h00, 8'h00, 8'hff, 8'hff};
    wr(OFS_ONCHIP_FLAG, 8'h00);
    wr(OFS_TIMER_CTRL, 8'h00);
    wr(OFS_EDGE_SELECT, 8'h01);
    wr(OFS_PIN_FUNCTION, 8'h1f);
    pin_irq <= 5'h1c;
    repeat (5) @(posedge mclk_in);
    rd(OFS_PIN_TIMER_FLAG, 8'h22, "fall");
    pin_irq <= 5'h1f;
    repeat (5) @(posedge mclk_in);
    rd(OFS_PIN_TIMER_FLAG, 8'h23, "rise");
    wr(OFS_WAKEUP_FUNC, 8'h08);
    wk_pin <= 8'he7;
    repeat (5) @(posedge mclk_in);
    rd(OFS_WAKEUP_FLAG, 8'h08, "wk_fall");
    wr(OFS_ENABLE_ONE, 8'h03);
    repeat (20) @(posedge mclk_in);
    chk("masked", 32'h0, {24'h0, starts});
    seq(VEC_PIN_BASE, 8'h00);
    rd(OFS_PIN_TIMER_FLAG, 8'h23, "kept");
    // flags are cleared only while masked
    wr(OFS_PIN_TIMER_FLAG, 8'hfe);
    rd(OFS_PIN_TIMER_FLAG, 8'h22, "clr0");
    seq(5'h05, 8'h01);
    wr(OFS_PIN_TIMER_FLAG, 8'h00);
    go(8'h02);
    chk("wk_off", 32'h2, {24'h0, starts});
    wr(OFS_ENABLE_ONE, 8'h23);
    repeat (40) @(posedge mclk_in);
    chk("wk_vec", {27'h0, VEC_WAKEUP}, {27'h0, vec});
    wr(OFS_WAKEUP_FLAG, 8'h00);
    rd(OFS_WAKEUP_FLAG, 8'h00, "wk_clr");
    wr(OFS_ENABLE_TWO, 8'hff);
    slow <= 1'b1;
    ev <= 16'h0010;
    @(posedge mclk_in);
    ev <= 16'h0000;
    rd(OFS_ONCHIP_FLAG, 8'h11, "int_flag");
    go(starts);
    chk("int_vec", 32'h1, {31'h0, vec >= VEC_INT_BASE && vec <= VEC_INT_LAST});
    chk("slow_lat", 32'h1, {31'h0, lat >= 17 && lat <= 29});
    report_and_stop();
  end
endmodule // tb_top
